// ===== hw/sipd_map.sv
// Cyclic process data image of a four-channel safety input unit
`timescale 1ns/1ps
`default_nettype none
`include "sipd_defs.svh"

// Function
// R1: Objects exchanged cyclically only; messages refused
// R2: Plain input byte one bits 0-3 channel values
// R3: Bit four carries safety connection state
// R4: Bit five carries combined terminal health
// R5: Bit six carries unit normal state
// R6: Bit seven flags input supply fault
// R7: Plain input byte two bits 0-3 channel status
// R8: Byte two bits four to seven reserved
// R9: Controller keeps first plain output byte zero
// R10: Controller keeps second plain output byte reserved
// R11: All objects zero after reset; reserved zero
// R12: Update and latch once per cyclic exchange
module sipd_map #(
  parameter int CHANNELS = `SIPD_CHANNELS // Safety input channels served
) (
  input  wire logic               ref_clk,        // 10 MHz clock
  input  wire logic               arst_n,         // Async reset, active low
  input  wire logic               cycle_strobe,   // One-cycle pulse per cyclic exchange
  input  wire sipd_pkg::sipd_unit_s unit_state,   // Live unit status
  input  wire sipd_pkg::sipd_frame_s slave_frame_in, // Frame from safety logic
  input  wire logic [7:0]         safety_in_data, // Safety input byte source
  input  wire sipd_pkg::sipd_frame_s master_frame_rx, // Frame from controller
  input  wire logic [7:0]         safety_out_rx,  // Safety output byte from controller
  input  wire logic [7:0]         plain_out_rx_first,  // Reserved output byte one
  input  wire logic [7:0]         plain_out_rx_second, // Reserved output byte two
  input  wire logic               msg_req,        // Acyclic message request pulse
  input  wire logic [15:0]        msg_index,      // Message object index
  input  wire logic [7:0]         msg_subindex,   // Message subindex
  output logic                    msg_ack,        // Message answer pulse
  output logic                    msg_refused,    // Message refused with ack
  output logic [7:0]              msg_abort_code, // Refusal code
  output sipd_pkg::sipd_frame_s   slave_frame_tx, // Outgoing frame image
  output logic [7:0]              safety_input_byte,         // Outgoing safety byte
  output logic [7:0]              plain_input_values_health, // Plain input byte one
  output logic [7:0]              plain_input_channel_status, // Plain input byte two
  output sipd_pkg::sipd_frame_s   master_frame_image, // Latched controller frame
  output logic [7:0]              safety_output_byte, // Latched safety output
  output logic                    plain_out_nonzero  // Controller broke reserved bytes
);
  sipd_pkg::sipd_msg_e msg_ff;
  logic                in_map;

  // Unit record and byte layout hold exactly four channel bits
  if (CHANNELS != `SIPD_CHANNELS) begin : g_channels_check
    $error("sipd_map serves only four channels");
  end

  // Image is only ever refreshed on the cyclic strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      slave_frame_tx    <= '{`SIPD_RST_BYTE, `SIPD_RST_WORD, `SIPD_RST_WORD}; // R11
      safety_input_byte <= `SIPD_RST_BYTE; // R11
    end else if (cycle_strobe) begin
      slave_frame_tx    <= slave_frame_in; // R12
      safety_input_byte <= safety_in_data; // R12
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      plain_input_values_health  <= `SIPD_RST_BYTE; // R11
      plain_input_channel_status <= `SIPD_RST_BYTE; // R11
    end else if (cycle_strobe) begin
      plain_input_values_health <= {unit_state.supply_fault, // R6
                                    unit_state.unit_ok,      // R5
                                    unit_state.terminal_ok,  // R4
                                    unit_state.connection_ok, // R3
                                    unit_state.channel_value}; // R2
      plain_input_channel_status <= {`SIPD_RSVD_NIBBLE, // R8
                                     unit_state.channel_status}; // R7
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      master_frame_image <= '{`SIPD_RST_BYTE, `SIPD_RST_WORD, `SIPD_RST_WORD}; // R11
      safety_output_byte <= `SIPD_RST_BYTE; // R11
    end else if (cycle_strobe) begin
      master_frame_image <= master_frame_rx; // R12
      safety_output_byte <= safety_out_rx;   // R12
    end
  end

  // Reserved output bytes are never stored; only a breach is reported
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      plain_out_nonzero <= 1'b0;
    end else if (cycle_strobe) begin
      plain_out_nonzero <= (plain_out_rx_first != `SIPD_RST_BYTE) || // R9
                           (plain_out_rx_second != `SIPD_RST_BYTE);  // R10
    end
  end

  // Every object of the map refuses message access, unknown ones too; in_map feeds a check
  assign in_map = ((msg_index >= `SIPD_IDX_SLAVE_FRAME && msg_index <= `SIPD_IDX_PLAIN_IN) ||
                   (msg_index >= `SIPD_IDX_MASTER_FRAME && msg_index <= `SIPD_IDX_PLAIN_OUT))
                  && msg_subindex <= `SIPD_SUB_THIRD;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      msg_ff <= sipd_pkg::SIPD_IDLE;
    end else begin
      case (msg_ff)
        sipd_pkg::SIPD_IDLE:  msg_ff <= msg_req ? sipd_pkg::SIPD_ABORT : sipd_pkg::SIPD_IDLE; // R1
        sipd_pkg::SIPD_ABORT: msg_ff <= sipd_pkg::SIPD_IDLE;
        default:              msg_ff <= sipd_pkg::SIPD_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      msg_abort_code <= `SIPD_RST_BYTE;
    end else if (msg_req && msg_ff == sipd_pkg::SIPD_IDLE) begin
      msg_abort_code <= `SIPD_ABORT_NOT_CYCLIC; // R1
    end
  end

  assign msg_ack     = (msg_ff == sipd_pkg::SIPD_ABORT);
  assign msg_refused = (msg_ff == sipd_pkg::SIPD_ABORT); // R1

  property p_msg_refused;
    @(posedge ref_clk) disable iff (!arst_n)
      (msg_req && msg_ff == sipd_pkg::SIPD_IDLE) |=> (msg_ack && msg_refused);
  endproperty
  a_msg_refused: assert property (p_msg_refused) else $error("message not refused"); // R1

  property p_values;
    @(posedge ref_clk) disable iff (!arst_n)
      cycle_strobe |=> plain_input_values_health[`SIPD_CH_MSB:0]
                       == $past(unit_state.channel_value);
  endproperty
  a_values: assert property (p_values) else $error("channel values wrong"); // R2

  property p_conn;
    @(posedge ref_clk) disable iff (!arst_n)
      cycle_strobe |=> plain_input_values_health[`SIPD_BIT_CONN]
                       == $past(unit_state.connection_ok);
  endproperty
  a_conn: assert property (p_conn) else $error("connection bit wrong"); // R3

  property p_term;
    @(posedge ref_clk) disable iff (!arst_n)
      cycle_strobe |=> plain_input_values_health[`SIPD_BIT_TERM]
                       == $past(unit_state.terminal_ok);
  endproperty
  a_term: assert property (p_term) else $error("terminal bit wrong"); // R4

  property p_unit;
    @(posedge ref_clk) disable iff (!arst_n)
      cycle_strobe |=> plain_input_values_health[`SIPD_BIT_UNIT_OK]
                       == $past(unit_state.unit_ok);
  endproperty
  a_unit: assert property (p_unit) else $error("unit bit wrong"); // R5

  property p_pwr;
    @(posedge ref_clk) disable iff (!arst_n)
      cycle_strobe |=> plain_input_values_health[`SIPD_BIT_PWR_ERR]
                       == $past(unit_state.supply_fault);
  endproperty
  a_pwr: assert property (p_pwr) else $error("supply bit wrong"); // R6

  property p_status;
    @(posedge ref_clk) disable iff (!arst_n)
      cycle_strobe |=> plain_input_channel_status[`SIPD_CH_MSB:0]
                       == $past(unit_state.channel_status);
  endproperty
  a_status: assert property (p_status) else $error("channel status wrong"); // R7

  property p_rsvd;
    @(posedge ref_clk) disable iff (!arst_n)
      plain_input_channel_status[`SIPD_RSVD_MSB:`SIPD_RSVD_LSB] == `SIPD_RSVD_NIBBLE;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set"); // R8

  property p_hold;
    @(posedge ref_clk) disable iff (!arst_n)
      !cycle_strobe |=> $stable(master_frame_image) && $stable(slave_frame_tx)
                        && $stable(safety_output_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("image changed outside exchange"); // R12

  property p_latch;
    @(posedge ref_clk) disable iff (!arst_n)
      cycle_strobe |=> master_frame_image == $past(master_frame_rx)
                       && safety_input_byte == $past(safety_in_data);
  endproperty
  a_latch: assert property (p_latch) else $error("exchange not latched"); // R12

  property p_frame_out;
    @(posedge ref_clk) disable iff (!arst_n)
      cycle_strobe |=> slave_frame_tx == $past(slave_frame_in)
                       && safety_output_byte == $past(safety_out_rx);
  endproperty
  a_frame_out: assert property (p_frame_out) else $error("outgoing frame not latched"); // R12

  property p_plain_hold;
    @(posedge ref_clk) disable iff (!arst_n)
      !cycle_strobe |=> $stable(plain_input_values_health) && $stable(plain_input_channel_status)
                        && $stable(safety_input_byte) && $stable(plain_out_nonzero);
  endproperty
  a_plain_hold: assert property (p_plain_hold) else $error("bytes moved between exchanges"); // R12

  property p_rsvd_flag;
    @(posedge ref_clk) disable iff (!arst_n)
      cycle_strobe |=> plain_out_nonzero == ($past(plain_out_rx_first) != `SIPD_RST_BYTE
                                             || $past(plain_out_rx_second) != `SIPD_RST_BYTE);
  endproperty
  a_rsvd_flag: assert property (p_rsvd_flag) else $error("reserved breach flag wrong"); // R9 R10

  // Even a well-formed map object address is refused
  property p_map_refused;
    @(posedge ref_clk) disable iff (!arst_n)
      (msg_req && in_map && msg_ff == sipd_pkg::SIPD_IDLE) |=> msg_refused
        && msg_abort_code == `SIPD_ABORT_NOT_CYCLIC;
  endproperty
  a_map_refused: assert property (p_map_refused) else $error("map object not refused"); // R1

  property p_ack_pulse;
    @(posedge ref_clk) disable iff (!arst_n)
      msg_ack |=> !msg_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle"); // R1

  // Looked at on release only; before the first edge the registers are still unknown
  property p_reset_image;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(arst_n) |-> slave_frame_tx == {`SIPD_RST_BYTE, `SIPD_RST_WORD, `SIPD_RST_WORD}
        && master_frame_image == {`SIPD_RST_BYTE, `SIPD_RST_WORD, `SIPD_RST_WORD}
        && safety_input_byte == `SIPD_RST_BYTE && safety_output_byte == `SIPD_RST_BYTE
        && plain_input_values_health == `SIPD_RST_BYTE
        && plain_input_channel_status == `SIPD_RST_BYTE
        && msg_abort_code == `SIPD_RST_BYTE && !plain_out_nonzero && !msg_ack;
  endproperty
  a_reset_image: assert property (p_reset_image) else $error("image not zero after reset"); // R11
endmodule : sipd_map
`default_nettype wire

// ===== hw/sipd_defs.svh
// Offsets, subindices, bit positions and reset values of the process data map
`ifndef SIPD_DEFS_SVH
`define SIPD_DEFS_SVH
`define SIPD_IDX_SLAVE_FRAME   16'h6000
`define SIPD_IDX_SAFE_IN       16'h6001
`define SIPD_IDX_PLAIN_IN      16'h6002
`define SIPD_IDX_MASTER_FRAME  16'h7000
`define SIPD_IDX_SAFE_OUT      16'h7001
`define SIPD_IDX_PLAIN_OUT     16'h7002
`define SIPD_SUB_COUNT         8'h00
`define SIPD_SUB_FIRST         8'h01
`define SIPD_SUB_SECOND        8'h02
`define SIPD_SUB_THIRD         8'h03
`define SIPD_BIT_CONN          4
`define SIPD_BIT_TERM          5
`define SIPD_BIT_UNIT_OK       6
`define SIPD_BIT_PWR_ERR       7
`define SIPD_CHANNELS          4
`define SIPD_CH_MSB            3
`define SIPD_RSVD_LSB          4
`define SIPD_RSVD_MSB          7
`define SIPD_RST_BYTE          8'h00
`define SIPD_RST_WORD          16'h0000
`define SIPD_RSVD_NIBBLE       4'h0
`define SIPD_ABORT_NOT_CYCLIC  8'h01
`endif

// ===== hw/sipd_pkg.sv
// Types of the safety input process data map
`default_nettype none
package sipd_pkg;
  typedef struct packed {
    logic [7:0]  command;
    logic [15:0] connection_ident;
    logic [15:0] check_word;
  } sipd_frame_s;

  typedef struct packed {
    logic [3:0] channel_value;
    logic [3:0] channel_status;
    logic       connection_ok;
    logic       terminal_ok;
    logic       unit_ok;
    logic       supply_fault;
  } sipd_unit_s;

  typedef enum logic [1:0] {
    SIPD_IDLE  = 2'b01,
    SIPD_ABORT = 2'b10
  } sipd_msg_e;
endpackage : sipd_pkg
`default_nettype wire

// ===== sim/sipd_ctrl_model.sv
// Controller model driving the unit's cyclic output objects
`timescale 1ns/1ps
`default_nettype none
module sipd_ctrl_model (
  input  wire logic             ref_clk,  // Clock
  input  wire logic             strobe,   // Exchange taken this edge
  input  wire logic             bad_rsvd, // Misuse reserved bytes
  output sipd_pkg::sipd_frame_s frame,    // Frame to unit
  output logic [7:0]            safe_out, // Safety output byte
  output logic [7:0]            rsvd_a,   // Reserved byte one
  output logic [7:0]            rsvd_b    // Reserved byte two
);
  initial frame = '0;
  initial safe_out = 8'h00;
  // New frame only once the unit took the last one
  always @(posedge ref_clk) begin
    if (strobe) begin
      frame    <= 40'({$urandom(), $urandom()});
      safe_out <= 8'($urandom());
    end
  end
  assign rsvd_a = bad_rsvd ? 8'h5a : 8'h00;
  assign rsvd_b = bad_rsvd ? 8'ha5 : 8'h00;
endmodule : sipd_ctrl_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench of the process data map
`timescale 1ns/1ps
`default_nettype none
`include "sipd_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
  logic                  ref_clk = 1'b0, arst_n = 1'b0, strobe = 1'b0, bad = 1'b0;
  logic                  msg_req = 1'b0, ack, refu, nz;
  sipd_pkg::sipd_unit_s  unit = '0;
  sipd_pkg::sipd_frame_s sf = '0, mf, sft, mfi;
  logic [7:0]            sin = 8'h00, so, ra, rb, abrt, sib, b1, b2, sob, msg_sub = 8'h00;
  logic [15:0]           msg_index = 16'h0000;
  logic [15:0]           idx [6] = '{`SIPD_IDX_SLAVE_FRAME, `SIPD_IDX_SAFE_IN,
    `SIPD_IDX_PLAIN_IN, `SIPD_IDX_MASTER_FRAME, `SIPD_IDX_SAFE_OUT, `SIPD_IDX_PLAIN_OUT};
  int                    bad_count = 0, checked = 0, cyc_cnt = 0;
  logic [7:0]            exp_q [$];

  sipd_map i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .cycle_strobe(strobe),
    .unit_state(unit), .slave_frame_in(sf), .safety_in_data(sin), .master_frame_rx(mf),
    .safety_out_rx(so), .plain_out_rx_first(ra), .plain_out_rx_second(rb),
    .msg_req(msg_req), .msg_index(msg_index), .msg_subindex(msg_sub), .msg_ack(ack),
    .msg_refused(refu), .msg_abort_code(abrt), .slave_frame_tx(sft),
    .safety_input_byte(sib), .plain_input_values_health(b1),
    .plain_input_channel_status(b2), .master_frame_image(mfi),
    .safety_output_byte(sob), .plain_out_nonzero(nz));
  sipd_ctrl_model i_ctrl (.ref_clk(ref_clk), .strobe(strobe), .bad_rsvd(bad),
    .frame(mf), .safe_out(so), .rsvd_a(ra), .rsvd_b(rb));

  initial forever #50 ref_clk = ~ref_clk;

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // Hang guard; the full run needs about 130 cycles
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      bad_count++;
      final_report;
    end
  end

  task automatic rchk;
    `CHK("reset_image", '0, {sft, sib, b1, b2, mfi, sob, nz, ack, refu, abrt})
  endtask : rchk

  // Byte one built bit by bit from the published layout
  function automatic logic [7:0] model_b1(input sipd_pkg::sipd_unit_s u);
    logic [7:0] v;
    v = `SIPD_RST_BYTE;
    for (int c = 0; c <= `SIPD_CH_MSB; c++) v[c] = u.channel_value[c];
    v[`SIPD_BIT_CONN]    = u.connection_ok;
    v[`SIPD_BIT_TERM]    = u.terminal_ok;
    v[`SIPD_BIT_UNIT_OK] = u.unit_ok;
    v[`SIPD_BIT_PWR_ERR] = u.supply_fault;
    return v;
  endfunction : model_b1

  task automatic xchg(input logic b);
    sipd_pkg::sipd_frame_s f;
    logic [7:0]            s;
    logic [7:0]            e;
    logic [7:0]            st;
    @(posedge ref_clk);
    unit <= 12'($urandom());
    sf <= 40'({$urandom(), $urandom()});
    sin <= 8'($urandom());
    bad <= b;
    strobe <= 1'b1;
    #1 f = mf;
    s = so;
    exp_q.push_back(model_b1(unit));
    exp_q.push_back({`SIPD_RSVD_NIBBLE, unit.channel_status});
    @(posedge ref_clk);
    strobe <= 1'b0;
    #1 e = exp_q.pop_front();
    st = exp_q.pop_front();
    `CHK("frame_out", sf, sft)
    `CHK("safe_in", sin, sib)
    `CHK("values_health", e, b1)
    `CHK("channel_status", st, b2)
    `CHK("frame_in", f, mfi)
    `CHK("safe_out", s, sob)
    `CHK("rsvd_flag", b, nz)
    @(posedge ref_clk);
    unit <= ~unit;
    @(posedge ref_clk);
    #1 `CHK("hold_between", e, b1)
    `CHK("hold_status", st, b2)
  endtask : xchg

  task automatic msg(input logic [15:0] ix);
    @(posedge ref_clk);
    msg_req <= 1'b1;
    msg_index <= ix;
    msg_sub <= 8'($urandom_range(3, 1));
    @(posedge ref_clk);
    msg_req <= 1'b0;
    #1 `CHK("ack_refused", 2'b11, {ack, refu})
    `CHK("abort_code", `SIPD_ABORT_NOT_CYCLIC, abrt)
    @(posedge ref_clk);
    #1 `CHK("ack_dropped", 2'b00, {ack, refu})
  endtask : msg

  initial begin
    void'($urandom(32'h1404a41a));
    repeat (12) @(posedge ref_clk);
    rchk;
    arst_n <= 1'b1;
    #1 rchk;
    $display("test reset done");
    xchg(1'b1);
    xchg(1'b0);
    repeat (20) xchg(1'($urandom()));
    $display("test exchange done");
    foreach (idx[i]) msg(idx[i]);
    msg(16'($urandom()));
    $display("test message done");
    @(posedge ref_clk);
    arst_n <= 1'b0;
    #1 rchk;
    @(posedge ref_clk);
    arst_n <= 1'b1;
    xchg(1'b0);
    $display("test second reset done");
    final_report;
  end
endmodule : tb
`default_nettype wire
